// *** io_mapper_defs.svh ***
// Purpose: Register offsets, field positions and reset values
// Assumes: Byte addresses on a plain strobe register port
// Notes: Definitions only
`ifndef IO_MAPPER_DEFS_SVH
`define IO_MAPPER_DEFS_SVH
`define OFS_IN5_SEL 5'h00
`define OFS_IN6_SEL 5'h04
`define OFS_RELAY_SEL 5'h08
`define OFS_NET_CTRL 5'h0C
`define OFS_CMP_SET 5'h10
`define OFS_STATUS 5'h14
`define RST_IN5_SEL 5'h00
`define RST_IN6_SEL 5'h00
`define RST_RELAY_SEL 4'h1
`define RST_NET_CTRL 1'h0
`define RST_CMP_SET 16'h03E8
`define CMP_HYST_DIV 16'h000A
`define CMP_SET_MIN 16'h0064
`define CMP_SET_MAX 16'h1388
`define IN_CODE_MAX_COMMON 5'h0C
`define IN_CODE_THERM_ALARM 5'h0F
`define IN_CODE_THERM_FAULT 5'h10
`define RELAY_CODE_MAX 4'hE
`define STAT_IN_LSB 0
`define STAT_RELAY_BIT 2
`define STAT_ENABLE_BIT 3
`define STAT_REMOTE_BIT 4
`define STAT_REVERSE_BIT 5
`define STAT_CMP_BIT 6
`endif

// *** io_mapper_pkg.sv ***
// Purpose: Types shared by the I/O function mapper
// Assumes: Codes as selected by software
// Notes: Offsets live in the defs header
package io_mapper_pkg;
	typedef enum logic [4:0] {
		IN_UNUSED = 5'h00, IN_RUN_STOP = 5'h01, IN_START3 = 5'h02,
		IN_STOP3 = 5'h03, IN_ENABLE = 5'h04, IN_LOCAL_REMOTE_SELECT = 5'h05,
		IN_JOG = 5'h06, IN_DIRECTION = 5'h07, IN_EXT_FAULT = 5'h08,
		IN_EXT_ALARM = 5'h09, IN_BRAKE = 5'h0A, IN_RESET = 5'h0B,
		IN_LOAD_USER = 5'h0C, IN_THERM_ALARM = 5'h0F,
		IN_THERM_FAULT = 5'h10
	} in_func_t;
	typedef enum logic [3:0] {
		OUT_UNUSED = 4'h0, OUT_RUNNING = 4'h1, OUT_FULL_VOLT = 4'h2,
		OUT_BYPASS = 4'h3, OUT_FORWARD = 4'h4, OUT_DC_BRAKE = 4'h5,
		OUT_NO_FAULT = 4'h6, OUT_FAULT = 4'h7, OUT_NO_ALARM = 4'h8,
		OUT_ALARM = 4'h9, OUT_HEALTHY = 4'hA, OUT_USER_PROG = 4'hB,
		OUT_NETWORK = 4'hC, OUT_CURRENT = 4'hD, OUT_SHUNT_TRIP = 4'hE
	} out_func_t;
	// Starter core conditions sampled by the relay selector
	typedef struct packed {
		logic running;
		logic full_voltage;
		logic bypass_engaged;
		logic reverse_rotation;
		logic dc_braking;
		logic decelerating;
		logic fault_active;
		logic alarm_active;
		logic user_program_bit;
		logic [6:0] power_faults;
		logic [15:0] motor_current;
	} core_status_t;
	// Commands decoded from the two input channels
	typedef struct packed {
		logic run_level;
		logic start_pulse;
		logic stop_pulse;
		logic general_enable;
		logic remote_select;
		logic jog_request;
		logic forward_contactor;
		logic reverse_contactor;
		logic ext_fault;
		logic ext_alarm;
		logic brake_request;
		logic fault_reset_pulse;
		logic load_user_one;
		logic load_user_two;
		logic thermistor_alarm;
		logic thermistor_fault;
	} input_cmd_t;
endpackage : io_mapper_pkg

// *** motor_starter_io_function_mapper.sv ***
// Purpose: Selectable-function digital inputs five/six and relay one
// Assumes: Core status from logic on ref_clk; contacts are raw pins
// Notes: Closed contact reads 1, open reads 0
//
// Contract
// R01 - Code 1: closed runs, open stops
// R02 - Code 2 start on close, 3 stop on open
// R03 - Code 4: enable only while closed
// R04 - Code 5 remote when closed; 6 jogs
// R05 - Code 7: open forward, closed reverse
// R06 - Code 8: open input raises external fault
// R07 - Code 9: open input raises external alarm
// R08 - Code 10: brake while closed
// R09 - Code 11: closing edge resets active fault
// R10 - Code 12: close loads set one, open two
// R11 - Codes 15/16 thermistor, channel six only
// R12 - Code 0 status only; reserved codes refused
// R13 - Relay follows its selected condition
// R14 - Relay code 0 stays de-energized
// R15 - Running follows start, stop, ramp end
// R16 - Full voltage until any disabling command
// R17 - Bypass follows bypass contactor engagement
// R18 - Code 4 closes in forward rotation
// R19 - Code 5 braking; 6..10 fault/alarm states
// R20 - DC braking energizes for whole braking
// R21 - Code 11 program bit, 12 network bit
// R22 - Code 13 current compare, 10% hysteresis
// R23 - Code 14 closes on power faults
// R24 - Input status: open 0, closed 1
`timescale 1ns/10ps
`include "io_mapper_defs.svh"

module motor_starter_io_function_mapper
	import io_mapper_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Field contacts
	input wire logic input_channel_five,
	input wire logic input_channel_six,
	// Starter core
	input core_status_t core_status,
	// Decoded commands, contact status and relay coil
	output input_cmd_t input_cmd,
	output logic [1:0] input_status,
	output logic relay_output_one
);

	// Decode helper used for both channels
	function automatic logic sel_is(input logic [4:0] sel,
		input in_func_t code);
		sel_is = (sel == code);
	endfunction : sel_is

	// Channel five takes 0..12, channel six also 15 and 16
	function automatic logic code_ok(input logic [4:0] code,
		input logic six);
		code_ok = (code <= `IN_CODE_MAX_COMMON) ||
			(six && (code == `IN_CODE_THERM_ALARM ||
			code == `IN_CODE_THERM_FAULT));
	endfunction : code_ok

	logic [4:0] input5_function_select;
	logic [4:0] input6_function_select;
	logic [3:0] relay_out1_function_select;
	logic network_output_control_word;
	logic [15:0] current_compare_setting;
	logic [1:0] sync_a;
	logic [1:0] level;
	logic [1:0] level_prev;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [4:0] sel [2];
	logic cmp_state;
	logic [15:0] hyst_floor;
	logic cmp_window;
	input_cmd_t next_cmd;
	logic next_relay;
	logic [31:0] next_rdata;

	// Write side; reserved codes are refused so old value stays
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			input5_function_select <= `RST_IN5_SEL;
			input6_function_select <= `RST_IN6_SEL;
			relay_out1_function_select <= `RST_RELAY_SEL;
			network_output_control_word <= `RST_NET_CTRL;
			current_compare_setting <= `RST_CMP_SET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`OFS_IN5_SEL: begin
					if (code_ok(reg_wdata[4:0], 1'b0)) begin // [R12] [R11]
						input5_function_select <= reg_wdata[4:0];
					end
				end
				`OFS_IN6_SEL: begin
					if (code_ok(reg_wdata[4:0], 1'b1)) begin // [R11] [R12]
						input6_function_select <= reg_wdata[4:0];
					end
				end
				`OFS_RELAY_SEL: begin
					if (reg_wdata[3:0] <= `RELAY_CODE_MAX) begin
						relay_out1_function_select <= reg_wdata[3:0];
					end
				end
				`OFS_NET_CTRL: begin
					network_output_control_word <= reg_wdata[0]; // [R21]
				end
				`OFS_CMP_SET: begin
					// Out-of-range settings kept out of the comparator
					if (reg_wdata[15:0] >= `CMP_SET_MIN &&
						reg_wdata[15:0] <= `CMP_SET_MAX) begin
						current_compare_setting <= reg_wdata[15:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (reg_addr)
			`OFS_IN5_SEL: next_rdata[4:0] = input5_function_select;
			`OFS_IN6_SEL: next_rdata[4:0] = input6_function_select;
			`OFS_RELAY_SEL: next_rdata[3:0] = relay_out1_function_select;
			`OFS_NET_CTRL: next_rdata[0] = network_output_control_word;
			`OFS_CMP_SET: next_rdata[15:0] = current_compare_setting;
			`OFS_STATUS: begin
				next_rdata[`STAT_IN_LSB +: 2] = input_status; // [R24]
				next_rdata[`STAT_RELAY_BIT] = relay_output_one;
				next_rdata[`STAT_ENABLE_BIT] = input_cmd.general_enable;
				next_rdata[`STAT_REMOTE_BIT] = input_cmd.remote_select;
				next_rdata[`STAT_REVERSE_BIT] = input_cmd.reverse_contactor;
				next_rdata[`STAT_CMP_BIT] = cmp_state;
			end
			default: begin
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Two-stage synchroniser for the field contacts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_a <= 2'h0;
			level <= 2'h0;
			level_prev <= 2'h0;
		end else begin
			sync_a <= {input_channel_six, input_channel_five};
			level <= sync_a;
			level_prev <= level;
		end
	end

	// Edges seen only after the synchroniser
	assign rise = level & ~level_prev;
	assign fall = ~level & level_prev;
	assign sel[0] = input5_function_select;
	assign sel[1] = input6_function_select;

	// Contact status: open 0, closed 1, any selected function
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			input_status <= 2'h0;
		end else begin
			input_status <= level; // [R24] [R12]
		end
	end

	// Both channels merged; a function on either channel acts
	always_comb begin
		next_cmd = '0;
		next_cmd.general_enable = 1'b1;
		next_cmd.forward_contactor = 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (sel_is(sel[i], IN_RUN_STOP) && level[i]) begin
				next_cmd.run_level = 1'b1; // [R01]
			end
			if (sel_is(sel[i], IN_START3) && rise[i]) begin
				next_cmd.start_pulse = 1'b1; // [R02]
			end
			if (sel_is(sel[i], IN_STOP3) && fall[i]) begin
				next_cmd.stop_pulse = 1'b1; // [R02]
			end
			// Any enabling contact that is open disables the starter
			if (sel_is(sel[i], IN_ENABLE) && !level[i]) begin
				next_cmd.general_enable = 1'b0; // [R03]
			end
			if (sel_is(sel[i], IN_LOCAL_REMOTE_SELECT) && level[i]) begin
				next_cmd.remote_select = 1'b1; // [R04]
			end
			if (sel_is(sel[i], IN_JOG) && level[i]) begin
				next_cmd.jog_request = 1'b1; // [R04]
			end
			// Contactors kept mutually exclusive by construction
			if (sel_is(sel[i], IN_DIRECTION) && level[i]) begin
				next_cmd.forward_contactor = 1'b0; // [R05]
				next_cmd.reverse_contactor = 1'b1; // [R05]
			end
			if (sel_is(sel[i], IN_EXT_FAULT) && !level[i]) begin
				next_cmd.ext_fault = 1'b1; // [R06]
			end
			if (sel_is(sel[i], IN_EXT_ALARM) && !level[i]) begin
				next_cmd.ext_alarm = 1'b1; // [R07]
			end
			if (sel_is(sel[i], IN_BRAKE) && level[i]) begin
				next_cmd.brake_request = 1'b1; // [R08]
			end
			// No reset pulse unless a fault is present
			if (sel_is(sel[i], IN_RESET) && rise[i] &&
				core_status.fault_active) begin
				next_cmd.fault_reset_pulse = 1'b1; // [R09]
			end
			if (sel_is(sel[i], IN_LOAD_USER) && rise[i]) begin
				next_cmd.load_user_one = 1'b1; // [R10]
			end
			if (sel_is(sel[i], IN_LOAD_USER) && fall[i]) begin
				next_cmd.load_user_two = 1'b1; // [R10]
			end
		end
		// Tripped thermistor opens the loop, seen as an open contact
		if (sel_is(sel[1], IN_THERM_ALARM) && !level[1]) begin
			next_cmd.thermistor_alarm = 1'b1; // [R11]
		end
		if (sel_is(sel[1], IN_THERM_FAULT) && !level[1]) begin
			next_cmd.thermistor_fault = 1'b1; // [R11]
		end
	end

	// Registered command outputs; pulses last one cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			input_cmd <= '0;
		end else begin
			input_cmd <= next_cmd;
		end
	end

	// Comparator valid only at full voltage without deceleration
	assign cmp_window = core_status.full_voltage &&
		core_status.running && !core_status.decelerating;
	assign hyst_floor = current_compare_setting -
		(current_compare_setting / `CMP_HYST_DIV);

	// Current compare with hysteresis of a tenth of the setting
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmp_state <= 1'b0;
		end else if (!cmp_window) begin
			cmp_state <= 1'b0; // [R22]
		end else if (core_status.motor_current >
			current_compare_setting) begin
			cmp_state <= 1'b1; // [R22]
		end else if (core_status.motor_current <= hyst_floor) begin
			cmp_state <= 1'b0; // [R22]
		end
	end

	// Relay condition selected by its function code
	always_comb begin
		next_relay = 1'b0;
		unique case (out_func_t'(relay_out1_function_select))
			OUT_UNUSED: next_relay = 1'b0; // [R14]
			OUT_RUNNING: next_relay = core_status.running; // [R15]
			OUT_FULL_VOLT: next_relay = core_status.full_voltage; // [R16]
			OUT_BYPASS: next_relay = core_status.bypass_engaged; // [R17]
			OUT_FORWARD: begin
				next_relay = core_status.running &&
					!core_status.reverse_rotation; // [R18]
			end
			OUT_DC_BRAKE: next_relay = core_status.dc_braking; // [R20] [R19]
			OUT_NO_FAULT: next_relay = !core_status.fault_active; // [R19]
			OUT_FAULT: next_relay = core_status.fault_active; // [R19]
			OUT_NO_ALARM: next_relay = !core_status.alarm_active; // [R19]
			OUT_ALARM: next_relay = core_status.alarm_active; // [R19]
			OUT_HEALTHY: begin
				next_relay = !core_status.fault_active &&
					!core_status.alarm_active; // [R19]
			end
			OUT_USER_PROG: next_relay = core_status.user_program_bit; // [R21]
			OUT_NETWORK: next_relay = network_output_control_word; // [R21]
			OUT_CURRENT: next_relay = cmp_state; // [R22]
			OUT_SHUNT_TRIP: next_relay = |core_status.power_faults; // [R23]
			default: next_relay = 1'b0;
		endcase
	end

	// Coil register; follows its condition one cycle later
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			relay_output_one <= 1'b0;
		end else begin
			relay_output_one <= next_relay; // [R13]
		end
	end

endmodule : motor_starter_io_function_mapper

// *** mapper_sva.sv ***
// Purpose: Port checker for the I/O function mapper
// Assumes: Bound to the mapper top, one clock domain
// Notes: Relay select and network bit are mirrored from writes
`timescale 1ns/10ps
`include "io_mapper_defs.svh"
module mapper_sva
	import io_mapper_pkg::*;
(
	// Clock, reset and register port
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Contacts and core
	input wire logic input_channel_five,
	input wire logic input_channel_six,
	input wire core_status_t core_status,
	// Outputs
	input wire input_cmd_t input_cmd,
	input wire logic [1:0] input_status,
	input wire logic relay_output_one
);
	logic [2:0] age;
	logic [3:0] rsel;
	logic net;
	wire ok = age[2];
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Settle count; mirrors refuse illegal codes like the block
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			age <= 3'h0;
			rsel <= 4'h1;
			net <= 1'b0;
		end else begin
			if (!ok)
				age <= age + 3'h1;
			if (reg_wr && reg_addr == `OFS_RELAY_SEL && reg_wdata[3:0] <= 4'hE)
				rsel <= reg_wdata[3:0];
			if (reg_wr && reg_addr == `OFS_NET_CTRL)
				net <= reg_wdata[0];
		end
	end
	AST_STATUS: assert property (
		ok |-> input_status ==
		{$past(input_channel_six, 3), $past(input_channel_five, 3)})
		else $error("status does not follow contacts");
	AST_OFF: assert property (
		ok && $past(rsel) == 4'h0 |-> !relay_output_one)
		else $error("unused relay energized");
	AST_RUN: assert property (
		ok && $past(rsel) == 4'h1 |->
		relay_output_one == $past(core_status.running))
		else $error("running relay wrong");
	AST_FWD: assert property (
		ok && $past(rsel) == 4'h4 |-> relay_output_one ==
		($past(core_status.running) && !$past(core_status.reverse_rotation)))
		else $error("forward relay wrong");
	AST_FLT: assert property (
		ok && $past(rsel) == 4'h7 |->
		relay_output_one == $past(core_status.fault_active))
		else $error("fault relay wrong");
	AST_NET: assert property (
		ok && $past(rsel) == 4'hC |-> relay_output_one == $past(net))
		else $error("network relay wrong");
	AST_TRIP: assert property (
		ok && $past(rsel) == 4'hE |->
		relay_output_one == ($past(core_status.power_faults) != 7'h00))
		else $error("shunt trip relay wrong");
	AST_START: assert property (
		input_cmd.start_pulse |-> ($rose(input_status[0]) ||
		$rose(input_status[1])) ##1 !input_cmd.start_pulse)
		else $error("start pulse without closing");
	AST_CLR: assert property (
		input_cmd.fault_reset_pulse |-> $past(core_status.fault_active) ||
		$past(core_status.fault_active, 2))
		else $error("fault reset without fault");
	AST_DIR: assert property (
		ok |-> input_cmd.forward_contactor != input_cmd.reverse_contactor)
		else $error("contactors not exclusive");
endmodule : mapper_sva
bind motor_starter_io_function_mapper mapper_sva i_sva (.ref_clk, .rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.input_channel_five, .input_channel_six, .core_status, .input_cmd,
	.input_status, .relay_output_one);

// *** field_model.sv ***
// Purpose: Field contacts wired to inputs five and six
// Assumes: Bench asks for contact states, 1 = closed
// Notes: LAG sets how slowly a contact moves
`timescale 1ns/10ps
module field_model #(
	parameter int LAG = 2
) (
	// Clock
	input wire logic ref_clk,
	// Requested states
	input wire logic [1:0] want,
	// Contact pins
	output logic [1:0] pins
);
	logic [2*LAG-1:0] sr = '0;
	// Mechanical lag, so the sync path sees a late contact
	always_ff @(posedge ref_clk) begin
		sr <= {sr[2*LAG-3:0], want};
	end
	assign pins = sr[2*LAG-1 -: 2];
endmodule : field_model

// *** tb_top.sv ***
// Purpose: Self-checking bench for the I/O function mapper
// Assumes: Strobe register port, contacts through field model
// Notes: One-cycle command pulses are tallied by a monitor
`timescale 1ns/10ps
`include "io_mapper_defs.svh"
module tb_top
	import io_mapper_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0] want = 2'h0;
	logic [1:0] pins;
	core_status_t core_status = '0;
	input_cmd_t input_cmd;
	logic [1:0] input_status;
	logic relay_output_one;
	int fail_count = 0;
	int checks_done = 0;
	int cnt [5] = '{default: 0};
	int base [5];
	logic [36:0] rv [6] = '{{`OFS_IN5_SEL, 32'h0}, {`OFS_IN6_SEL, 32'h0},
		{`OFS_RELAY_SEL, 32'h1}, {`OFS_NET_CTRL, 32'h0},
		{`OFS_CMP_SET, 32'h3E8}, {5'h18, 32'h0}};
	logic [36:0] bad [5] = '{{`OFS_IN5_SEL, 32'hD}, {`OFS_IN5_SEL, 32'hF},
		{`OFS_IN6_SEL, 32'hD}, {`OFS_RELAY_SEL, 32'hF},
		{`OFS_CMP_SET, 32'h63}};
	logic [5:0] lv [12] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
		6'h09, 6'h0A, 6'h21, 6'h27, 6'h2F, 6'h30};
	logic [9:0] pt [5] = '{10'h050, 10'h068, 10'h160, 10'h183, 10'h164};
	logic [16:0] cur [4] = '{17'h103E9, 17'h103B6, 17'h00384, 17'h103E9};
	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	field_model #(.LAG(2)) i_field (.ref_clk, .want, .pins);
	motor_starter_io_function_mapper i_dut (.ref_clk, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.input_channel_five(pins[0]), .input_channel_six(pins[1]),
		.core_status, .input_cmd, .input_status, .relay_output_one);
	// Tally pulses: start, stop, fault reset, set one, set two
	always @(posedge ref_clk) begin
		for (int k = 0; k < 5; k++)
			cnt[k] <= cnt[k] + int'({input_cmd.start_pulse,
				input_cmd.stop_pulse, input_cmd.fault_reset_pulse,
				input_cmd.load_user_one, input_cmd.load_user_two} >> (4 - k) & 1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
		@(posedge ref_clk);
	endtask : rdc
	// Move contacts, then give sync and decode time to settle
	task automatic pin(input logic [1:0] w);
		want <= w;
		repeat (8) @(posedge ref_clk);
	endtask : pin
	function automatic logic fld(input input_cmd_t c, input logic [4:0] k);
		case (k)
			5'h01: fld = c.run_level;
			5'h04: fld = c.general_enable;
			5'h05: fld = c.remote_select;
			5'h06: fld = c.jog_request;
			5'h07: fld = c.reverse_contactor;
			5'h08: fld = c.ext_fault;
			5'h09: fld = c.ext_alarm;
			5'h0A: fld = c.brake_request;
			5'h0F: fld = c.thermistor_alarm;
			default: fld = c.thermistor_fault;
		endcase
	endfunction : fld
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#200us;
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (rv[i]) rdc(rv[i][36:32], rv[i][31:0]);
		foreach (bad[i]) wr(bad[i][36:32], bad[i][31:0]);
		foreach (rv[i]) rdc(rv[i][36:32], rv[i][31:0]);
		$display("registers done");
		foreach (lv[i]) begin
			wr(lv[i][5] ? `OFS_IN6_SEL : `OFS_IN5_SEL, 32'(lv[i][4:0]));
			for (int c = 0; c < 2; c++) begin
				pin({2{c[0]}});
				chk(fld(input_cmd, lv[i][4:0]), c[0] ^ (lv[i][4:0] inside
					{5'h08, 5'h09, 5'h0F, 5'h10}));
				chk(input_status, {2{c[0]}});
			end
			wr(lv[i][5] ? `OFS_IN6_SEL : `OFS_IN5_SEL, 32'h0);
		end
		$display("level codes done");
		pin(2'h0);
		foreach (pt[i]) begin
			core_status.fault_active <= (i == 4);
			wr(`OFS_IN5_SEL, 32'(pt[i][9:5]));
			base = cnt;
			pin(2'h1);
			pin(2'h0);
			for (int k = 0; k < 5; k++)
				chk(cnt[k] - base[k], pt[i][4-k]);
		end
		$display("edge codes done");
		for (int r = 0; r < 15; r++) begin
			if (r == 13)
				continue;
			wr(`OFS_RELAY_SEL, r);
			for (int a = 0; a < 2; a++) begin
				core_status <= a ? core_status_t'({9'h1D7, 7'h01, 16'h0}) : '0;
				wr(`OFS_NET_CTRL, a);
				// Coil has already taken the new net bit at the second edge inside wr
				#1 chk(relay_output_one, r != 0 &&
					((r inside {6, 8, 10}) ^ a[0]));
				@(posedge ref_clk);
			end
		end
		$display("relay codes done");
		wr(`OFS_RELAY_SEL, 32'hD);
		foreach (cur[i]) begin
			core_status <= core_status_t'({9'h180, 7'h0, cur[i][15:0]});
			repeat (4) @(posedge ref_clk);
			chk(relay_output_one, cur[i][16]);
		end
		// Status: relay, enable and compare state set, contacts open
		rdc(`OFS_STATUS, 32'h4C);
		core_status.decelerating <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk(relay_output_one, 32'h0);
		$display("current compare done");
		// Reset in mid-run must bring every register back
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (rv[i]) rdc(rv[i][36:32], rv[i][31:0]);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule : tb_top
